// >>> bench/tb_top.sv
// Self-checking bench for the two-wire slave transmitter.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst;
	logic [3:0]  adr_a;
	logic        rd_a;
	logic        wr_a;
	logic [31:0] wd_a;
	logic [31:0] rdata;
	logic        waitreq;
	logic        scl_oe;
	logic        sda_oe;
	logic        scl_o;
	logic        sda_o;
	logic        scl_low;
	logic        sda_low;
	logic        sleep;
	logic        arb;
	logic        wake;
	logic        start_gen;
	wire logic   scl;
	wire logic   sda;
	int          miscompares = 0;
	int          n_tests = 0;
	int          starts = 0;
	int          exp_starts = 0;
	int          seed;
	logic [6:0]  own;
	logic [7:0]  q;
	logic        a;
	// Both lines have pull-ups
	assign scl = (scl_oe ? scl_o : 1'b1) & ~scl_low;
	assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
	serial_slave_tx uut (.CLOCK_I(clk), .SRST_I(rst), .AVS_ADDRESS_I(adr_a), .AVS_READ_I(rd_a),
		.AVS_WRITE_I(wr_a), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wd_a),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .SCL_I(scl), .SCL_O(scl_o),
		.SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SLEEP_I(sleep),
		.ARB_LOST_I(arb), .WAKE_O(wake), .START_GEN_O(start_gen));
	two_wire_master_model m (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(scl_low),
		.sda_low_o(sda_low));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (start_gen === 1'b1) begin
			starts <= starts + 1;
		end
	end
	task automatic end_of_test;
		if (miscompares == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] d,
		output logic [7:0] r);
		@(posedge clk);
		adr_a <= ad;
		wr_a <= w;
		rd_a <= ~w;
		wd_a <= {24'h0, d};
		// Only the watchdog ends a wait that never finishes
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		r = rdata[7:0];
		wr_a <= 1'b0;
		rd_a <= 1'b0;
	endtask : bus
	function automatic logic [7:0] st_exp(input logic last, input logic nack);
		if (nack) begin
			return serial_slave_tx_pkg::STAT_ST_DATA_NACK;
		end
		return last ? serial_slave_tx_pkg::STAT_ST_LAST_ACK : serial_slave_tx_pkg::STAT_ST_DATA_ACK;
	endfunction : st_exp
	// One read transfer: n bytes, nk = master refuses the last byte
	task automatic xfer(input int n, input logic nk, input logic ab, input logic sl,
		input logic sr);
		logic [7:0] d;
		logic [7:0] v;
		logic       k;
		sleep <= sl;
		m.start();
		arb <= ab;
		@(posedge clk);
		arb <= 1'b0;
		m.send({own, 1'b1}, k);
		chk(k, 0);
		chk({scl_oe, scl}, 2'b10);
		chk(wake, sl);
		bus(0, 4'h8, 8'h00, q);
		chk(q, ab ? serial_slave_tx_pkg::STAT_ST_ARB_LOST : serial_slave_tx_pkg::STAT_ST_ADDRESSED);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			bus(1, 4'hC, d, q);
			bus(1, 4'h4, (i == n - 1) ? 8'h84 : 8'hC4, q);
			m.recv((i == n - 1) ? nk : 1'b0, v);
			chk(v, d);
			bus(0, 4'h8, 8'h00, q);
			chk(q, st_exp(i == n - 1, i == n - 1 && nk));
		end
		// Refused last byte: acknowledge stays off to probe the isolated state
		bus(1, 4'h4, {1'b1, ~nk, sr, 5'h04}, q);
		if (!nk) begin
			m.recv(1'b1, v);
			chk(v, 8'hFF);
		end
		m.stop();
		sleep <= 1'b0;
		chk(wake, 0);
		if (nk) begin
			m.start();
			m.send({own, 1'b1}, k);
			chk(k, 1);
			m.stop();
			bus(1, 4'h4, 8'h44, q);
		end
		exp_starts += int'(sr);
		repeat (20) @(posedge clk);
		chk(starts, exp_starts);
	endtask : xfer
	initial begin
		seed = 32'h79b60fc4;
		rst = 1'b1;
		adr_a = 4'h0;
		rd_a = 1'b0;
		wr_a = 1'b0;
		wd_a = 32'h0;
		sleep = 1'b0;
		arb = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		bus(0, 4'h0, 8'h00, q);
		chk(q, 8'hFE);
		bus(0, 4'h8, 8'h00, q);
		chk(q, 8'hF8);
		bus(0, 4'h2, 8'h00, q);
		chk(q, 8'h00);
		own = {1'b1, 6'($random(seed))};
		bus(1, 4'h0, {own, 1'b0}, q);
		bus(1, 4'h4, 8'h44, q);
		// Data write with the flag clear is dropped and flagged
		bus(1, 4'hC, 8'h55, q);
		bus(0, 4'h4, 8'h00, q);
		chk(q, 8'h4C);
		m.start();
		m.send({own ^ 7'h01, 1'b1}, a);
		chk(a, 1);
		m.stop();
		m.start();
		m.send(8'h00, a);
		chk(a, 1);
		m.stop();
		bus(1, 4'h4, 8'h04, q);
		m.start();
		m.send({own, 1'b1}, a);
		chk(a, 1);
		m.stop();
		bus(1, 4'h4, 8'h44, q);
		m.start();
		m.send({own, 1'b0}, a);
		chk(a, 0);
		bus(0, 4'h8, 8'h00, q);
		chk(q, serial_slave_tx_pkg::STAT_SR_ADDRESSED);
		bus(1, 4'h4, 8'hC4, q);
		m.stop();
		bus(1, 4'h0, {own, 1'b1}, q);
		m.start();
		m.send(8'h00, a);
		chk(a, 0);
		bus(0, 4'h8, 8'h00, q);
		chk(q[2:0], 3'h0);
		bus(1, 4'h4, 8'hC4, q);
		m.stop();
		xfer(3, 1'b1, 1'b0, 1'b0, 1'b0);
		xfer(1, 1'b0, 1'b0, 1'b0, 1'b1);
		xfer(2, 1'b1, 1'b1, 1'b0, 1'b1);
		xfer(2, 1'b0, 1'b0, 1'b1, 1'b0);
		for (int j = 0; j < 4; j++) begin
			xfer(1 + ($random(seed) & 3), 1'($random(seed)), 1'b0, 1'b0, 1'b0);
		end
		end_of_test();
	end
	// Watchdog: the whole sequence needs well under this span
	initial begin
		repeat (50000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire

// >>> bench/two_wire_master_model.sv
// Behavioural master receiver driving the two-wire bus from the far side.
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_model (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var logic  scl_low_o,
	output var logic  sda_low_o
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic half;
		repeat (8) @(posedge clk_i);
	endtask : half
	// Slave may stretch the clock low; wait is bounded
	task automatic rise;
		int n;
		n = 0;
		scl_low_o <= 1'b0;
		@(posedge clk_i);
		while (scl_i !== 1'b1 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
	endtask : rise
	task automatic start;
		sda_low_o <= 1'b1;
		half();
		scl_low_o <= 1'b1;
		half();
	endtask : start
	// Data changes only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low_o <= ~b;
		half();
		rise();
		half();
		r = sda_i;
		scl_low_o <= 1'b1;
		half();
	endtask : bit_io
	task automatic send(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], ack);
		end
		bit_io(1'b1, ack);
	endtask : send
	task automatic recv(input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, v[i]);
		end
		bit_io(nack, r);
	endtask : recv
	task automatic stop;
		sda_low_o <= 1'b1;
		half();
		rise();
		half();
		sda_low_o <= 1'b0;
		half();
	endtask : stop
endmodule : two_wire_master_model
`default_nettype wire

// >>> core/serial_slave_tx.sv
// Two-wire bus slave transmitter with Avalon-MM register access.
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module serial_slave_tx (
	input  wire logic        CLOCK_I,
	input  wire logic        SRST_I,
	input  wire logic [3:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE_O,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_O,
	input  wire logic        SLEEP_I,
	input  wire logic        ARB_LOST_I,
	output logic             WAKE_O,
	output logic             START_GEN_O
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_TX, ST_TX_ACK, ST_IGNORE
	} state_t;

	state_t      state;
	logic        scl_s1, scl_s2, scl_d;
	logic        sda_s1, sda_s2, sda_d;
	logic [7:0]  own_slave_address;
	logic [7:0]  serial_data_reg;
	logic        interrupt_flag, acknowledge_enable, start_request, stop_request;
	logic        write_collision_flag, interface_enable, interrupt_enable;
	logic [4:0]  status_code;
	logic [7:0]  shift;
	logic [2:0]  bit_cnt;
	logic        ack_phase, dir_read, last_byte, ack_bit, arb_lost;
	logic        sda_drive, start_pending, served;

	function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own,
			input logic ack_en);
		logic own_hit;
		logic gc_hit;
		own_hit = (rx[7:1] == own[7:1]);
		gc_hit  = own[serial_slave_tx_pkg::OWN_GC_ENABLE]
			&& (rx[7:1] == serial_slave_tx_pkg::GENERAL_CALL_ADDRESS);
		addr_match = ack_en && (own_hit || gc_hit);
	endfunction : addr_match

	function automatic logic [4:0] code_of(input logic [7:0] stat);
		code_of = stat[7:3];
	endfunction : code_of

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d  <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_s1 <= SCL_I;
			scl_s2 <= scl_s1;
			scl_d  <= scl_s2;
			sda_s1 <= SDA_I;
			sda_s2 <= sda_s1;
			sda_d  <= sda_s2;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det, flag_set, flag_clr, bus_acc;
	logic [7:0] rx_byte, next_status;
	assign scl_rise  = scl_s2 && !scl_d;
	assign scl_fall  = !scl_s2 && scl_d;
	assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
	assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2;
	assign rx_byte   = {shift[6:0], sda_s2};
	assign bus_acc   = (AVS_READ_I || AVS_WRITE_I) && served;
	assign flag_clr  = bus_acc && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
		&& (AVS_ADDRESS_I == serial_slave_tx_pkg::OFF_SERIAL_CONTROL)
		&& AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_INTERRUPT_FLAG];
	assign flag_set  = interface_enable && scl_fall
		&& ((state == ST_ADDR_ACK && ack_phase) || state == ST_TX_ACK);

	// Status chosen for the event that raises the flag
	always_comb begin
		next_status = serial_slave_tx_pkg::STAT_ST_DATA_NACK;
		if (state == ST_ADDR_ACK) begin
			if (!dir_read)
				next_status = serial_slave_tx_pkg::STAT_SR_ADDRESSED;
			else if (arb_lost)
				next_status = serial_slave_tx_pkg::STAT_ST_ARB_LOST;
			else
				next_status = serial_slave_tx_pkg::STAT_ST_ADDRESSED;
		end else if (!ack_bit) begin
			next_status = last_byte ? serial_slave_tx_pkg::STAT_ST_LAST_ACK
				: serial_slave_tx_pkg::STAT_ST_DATA_ACK;
		end
	end

	// Bus protocol state machine
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			state       <= ST_IDLE;
			shift       <= 8'h00;
			bit_cnt     <= 3'h0;
			ack_phase   <= 1'b0;
			dir_read    <= 1'b0;
			last_byte   <= 1'b0;
			ack_bit     <= 1'b1;
			sda_drive   <= 1'b0;
			status_code <= 5'h00;
		end else if (!interface_enable) begin
			state     <= ST_IDLE;
			sda_drive <= 1'b0;
		end else if (state != ST_HOLD && (start_det || stop_det)) begin
			// Bus watched even while acknowledge is off
			state     <= start_det ? ST_ADDR : ST_IDLE;
			bit_cnt   <= 3'h0;
			sda_drive <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE, ST_IGNORE: begin
					sda_drive <= 1'b0;
				end
				ST_ADDR: if (scl_rise) begin
					shift   <= rx_byte;
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == serial_slave_tx_pkg::LAST_BIT_INDEX) begin
						dir_read  <= sda_s2;
						ack_phase <= 1'b0;
						// Sleep matching uses the same path
						state <= addr_match(rx_byte, own_slave_address, acknowledge_enable)
							? ST_ADDR_ACK : ST_IGNORE;
					end
				end
				ST_ADDR_ACK: if (scl_fall) begin
					if (!ack_phase) begin
						ack_phase <= 1'b1;
						sda_drive <= 1'b1;
					end else begin
						sda_drive   <= 1'b0;
						status_code <= code_of(next_status);
						state       <= ST_HOLD;
					end
				end
				ST_HOLD: if (!interrupt_flag) begin
					if (status_code == code_of(serial_slave_tx_pkg::STAT_ST_ADDRESSED)
							|| status_code == code_of(serial_slave_tx_pkg::STAT_ST_ARB_LOST)
							|| status_code == code_of(serial_slave_tx_pkg::STAT_ST_DATA_ACK)) begin
						shift     <= serial_data_reg;
						bit_cnt   <= 3'h0;
						last_byte <= !acknowledge_enable;
						sda_drive <= !serial_data_reg[7];
						state     <= ST_TX;
					end else begin
						// Receiver path and finished transfers both drop out here
						state <= ST_IGNORE;
					end
				end
				ST_TX: if (scl_fall) begin
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == serial_slave_tx_pkg::LAST_BIT_INDEX) begin
						sda_drive <= 1'b0;
						state     <= ST_TX_ACK;
					end else begin
						shift     <= {shift[6:0], 1'b1};
						sda_drive <= !shift[6];
					end
				end
				ST_TX_ACK: begin
					if (scl_rise)
						ack_bit <= sda_s2;
					if (scl_fall) begin
						status_code <= code_of(next_status);
						state       <= ST_HOLD;
					end
				end
			endcase
		end
	end

	// Arbitration loss is remembered until the next stop or the next interrupt flag set
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I)
			arb_lost <= 1'b0;
		else if (ARB_LOST_I)
			arb_lost <= 1'b1;
		else if (stop_det || flag_set)
			arb_lost <= 1'b0;
	end

	// Interrupt flag and wake request: a set beats a clear in the same cycle
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			interrupt_flag <= 1'b0;
			WAKE_O         <= 1'b0;
		end else if (flag_set) begin
			interrupt_flag <= 1'b1;
			WAKE_O         <= SLEEP_I;
		end else if (flag_clr) begin
			interrupt_flag <= 1'b0;
			WAKE_O         <= 1'b0;
		end
	end

	// Deferred START once the bus goes quiet
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			start_pending <= 1'b0;
			START_GEN_O   <= 1'b0;
		end else begin
			START_GEN_O <= 1'b0;
			// The request bit written with the clearing write counts, not the stored one
			if (state == ST_HOLD && flag_clr
					&& AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_START_REQUEST]
					&& (status_code == code_of(serial_slave_tx_pkg::STAT_ST_DATA_NACK)
					|| status_code == code_of(serial_slave_tx_pkg::STAT_ST_LAST_ACK)))
				start_pending <= 1'b1;
			else if (start_pending && state == ST_IDLE && scl_s2 && sda_s2) begin
				start_pending <= 1'b0;
				START_GEN_O   <= 1'b1;
			end
		end
	end

	// One wait state per access; the request is served on its second cycle
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I)
			served <= 1'b0;
		else
			served <= (AVS_READ_I || AVS_WRITE_I) && !served;
	end
	assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !served;

	// Register writes
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			own_slave_address    <= serial_slave_tx_pkg::RST_OWN_SLAVE_ADDRESS;
			serial_data_reg      <= serial_slave_tx_pkg::RST_SERIAL_DATA_REG;
			acknowledge_enable   <= 1'b0;
			start_request        <= 1'b0;
			stop_request         <= 1'b0;
			interface_enable     <= 1'b0;
			interrupt_enable     <= 1'b0;
			write_collision_flag <= 1'b0;
		end else if (bus_acc && AVS_WRITE_I && AVS_BYTEENABLE_I[0]) begin
			unique case (AVS_ADDRESS_I)
				serial_slave_tx_pkg::OFF_OWN_SLAVE_ADDRESS:
					own_slave_address <= AVS_WRITEDATA_I[7:0];
				serial_slave_tx_pkg::OFF_SERIAL_CONTROL: begin
					acknowledge_enable <= AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_ACK_ENABLE];
					start_request      <= AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_START_REQUEST];
					stop_request       <= AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_STOP_REQUEST];
					interface_enable   <= AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_IFACE_ENABLE];
					interrupt_enable   <= AVS_WRITEDATA_I[serial_slave_tx_pkg::CTL_INT_ENABLE];
				end
				serial_slave_tx_pkg::OFF_SERIAL_DATA_REG: begin
					// Only loadable while the flag holds the bus
					if (interrupt_flag) begin
						serial_data_reg      <= AVS_WRITEDATA_I[7:0];
						write_collision_flag <= 1'b0;
					end else begin
						write_collision_flag <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is captured in the wait cycle so it stands when waitrequest drops
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			AVS_READDATA_O <= 32'h00000000;
		end else if (AVS_READ_I && !served) begin
			unique case (AVS_ADDRESS_I)
				serial_slave_tx_pkg::OFF_OWN_SLAVE_ADDRESS:
					AVS_READDATA_O <= {24'h000000, own_slave_address};
				serial_slave_tx_pkg::OFF_SERIAL_CONTROL:
					AVS_READDATA_O <= {24'h000000, interrupt_flag, acknowledge_enable,
						start_request, stop_request, write_collision_flag,
						interface_enable, 1'b0, interrupt_enable};
				serial_slave_tx_pkg::OFF_SERIAL_STATUS:
					// Prescaler bits always read zero
					AVS_READDATA_O <= {24'h000000, interrupt_flag
						? {status_code, 3'h0} : serial_slave_tx_pkg::STAT_NO_INFO};
				serial_slave_tx_pkg::OFF_SERIAL_DATA_REG:
					AVS_READDATA_O <= {24'h000000, serial_data_reg};
				default:
					AVS_READDATA_O <= 32'h00000000;
			endcase
		end
	end

	// Long wake-up start times keep SCL low just as long
	assign SCL_O    = 1'b0;
	assign SCL_OE_O = interrupt_flag && state == ST_HOLD;
	assign SDA_O    = 1'b0;
	assign SDA_OE_O = sda_drive;

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);

	sequence addr_complete;
		state == ST_ADDR && scl_rise && bit_cnt == serial_slave_tx_pkg::LAST_BIT_INDEX;
	endsequence

	a_own_addr_ack: assert property (addr_complete ##0 (rx_byte[7:1] == own_slave_address[7:1]) ##0 acknowledge_enable |=> state == ST_ADDR_ACK) else $error("own address not acknowledged");
	a_gc_disabled: assert property (addr_complete ##0 (rx_byte[7:1] == 7'h00) ##0 !own_slave_address[0] ##0 (own_slave_address[7:1] != 7'h00) |=> state == ST_IGNORE) else $error("general call answered while disabled");
	a_ack_off: assert property (addr_complete ##0 !acknowledge_enable |=> state == ST_IGNORE) else $error("address answered with acknowledge off");
	a_read_status: assert property (flag_set && state == ST_ADDR_ACK && dir_read && !arb_lost |=> interrupt_flag && status_code == 5'h15) else $error("status after read address wrong");
	a_arb_status: assert property (flag_set && state == ST_ADDR_ACK && dir_read && arb_lost |=> status_code == 5'h16) else $error("status after lost arbitration wrong");
	a_nack_status: assert property (flag_set && state == ST_TX_ACK && ack_bit |=> status_code == 5'h18) else $error("status after not acknowledge wrong");
	a_byte_status: assert property (flag_set && state == ST_TX_ACK && !ack_bit |=> status_code == (last_byte ? 5'h19 : 5'h17)) else $error("status after acknowledged byte wrong");
	a_stretch_hold: assert property ($rose(interrupt_flag) |-> SCL_OE_O [*2]) else $error("clock not stretched after flag set");
	a_last_release: assert property (state == ST_HOLD && $fell(interrupt_flag) && status_code[4:3] == 2'b11 |=> state == ST_IGNORE ##1 !SDA_OE_O) else $error("not released after last byte");
	a_sleep_wake: assert property (flag_set && SLEEP_I |=> WAKE_O && SCL_OE_O) else $error("sleep match did not wake");

endmodule : serial_slave_tx
`default_nettype wire

// >>> core/serial_slave_tx_pkg.sv
// Constants for the two-wire slave transmitter: register map, fields, codes.
package serial_slave_tx_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [3:0] OFF_OWN_SLAVE_ADDRESS = 4'h0;
	localparam logic [3:0] OFF_SERIAL_CONTROL    = 4'h4;
	localparam logic [3:0] OFF_SERIAL_STATUS     = 4'h8;
	localparam logic [3:0] OFF_SERIAL_DATA_REG   = 4'hC;

	// Control register bit positions
	localparam int CTL_INTERRUPT_FLAG  = 7;
	localparam int CTL_ACK_ENABLE      = 6;
	localparam int CTL_START_REQUEST   = 5;
	localparam int CTL_STOP_REQUEST    = 4;
	localparam int CTL_WRITE_COLLISION = 3;
	localparam int CTL_IFACE_ENABLE    = 2;
	localparam int CTL_INT_ENABLE      = 0;

	// Own address register: address in bits 7:1, general call enable in bit 0
	localparam int OWN_GC_ENABLE = 0;

	// Reset values
	localparam logic [7:0] RST_OWN_SLAVE_ADDRESS = 8'hFE;
	localparam logic [7:0] RST_SERIAL_DATA_REG   = 8'hFF;

	// Status codes, prescaler bits zero; code field is bits 7:3
	localparam logic [7:0] STAT_NO_INFO      = 8'hF8;
	localparam logic [7:0] STAT_SR_ADDRESSED = 8'h60;
	localparam logic [7:0] STAT_ST_ADDRESSED = 8'hA8;
	localparam logic [7:0] STAT_ST_ARB_LOST  = 8'hB0;
	localparam logic [7:0] STAT_ST_DATA_ACK  = 8'hB8;
	localparam logic [7:0] STAT_ST_DATA_NACK = 8'hC0;
	localparam logic [7:0] STAT_ST_LAST_ACK  = 8'hC8;

	localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
	localparam logic [2:0] LAST_BIT_INDEX       = 3'h7;

endpackage : serial_slave_tx_pkg
